// >>> src/rgp_top.sv
// Top of the RGMII pad skew block: management portal, skew registers, pad offsets,
// receive in-band status and transmit sampling.
// Assumes a management frame engine presents decoded register accesses on core_clk.
`timescale 1ns/1ns
module rgp_top import rgp_pkg::*; (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire rgp_status_s status,
    input wire rgp_byte_s rx_in,
    output rgp_pin_s rx_pin,
    output rgp_delay_s pad_delay,
    input wire logic tx_clk_pin,
    input wire logic tx_ctl_pin,
    input wire logic [3:0] txd_pin,
    output rgp_byte_s tx_out,
    output logic tx_valid
);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [4:0] mmd_dev;
        logic [1:0] mmd_func;
        logic [15:0] mmd_addr;
        logic [15:0] skew_ctrl;
        logic [15:0] skew_rxd;
        logic [15:0] skew_txd;
        logic [15:0] skew_clk;
        logic [15:0] rdata;
        logic rvalid;
        rgp_delay_s delay;
    } rgp_top_state_s;

    rgp_top_state_s state_r;
    rgp_top_state_s state_nxt;
    logic data_mode;
    logic skew_sel;
    logic addr_step;
    logic [15:0] skew_rd;

    ////////////////////////////////////////////////////////////////////////////////
    // Skew register read-back; unknown device-2 registers read zero
    function automatic logic [15:0] skew_read(
        input rgp_top_state_s s,
        input logic [15:0] addr
    );
        case (addr)
            SKEW_REG_CTRL: skew_read = s.skew_ctrl;
            SKEW_REG_RXD: skew_read = s.skew_rxd;
            SKEW_REG_TXD: skew_read = s.skew_txd;
            SKEW_REG_CLK: skew_read = s.skew_clk;
            default: skew_read = '0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reset image: every skew field neutral, reserved bits zero.
    // Built as a constant so the asynchronous reset loads no live logic.
    function automatic rgp_top_state_s reset_image();
        rgp_top_state_s s;
        s = '0;
        s.skew_ctrl = SKEW_CTRL_RST;
        s.skew_rxd = SKEW_RXD_RST;
        s.skew_txd = SKEW_TXD_RST;
        s.skew_clk = SKEW_CLK_RST;
        s.delay.rx_clk = RX_CLK_LEAD_STEPS;
        return s;
    endfunction

    localparam rgp_top_state_s RESET_VAL = reset_image();

    // Portal decode; any function other than address selects data
    assign data_mode = (state_r.mmd_func != MMD_FUNC_ADDR);
    assign skew_sel = data_mode && (state_r.mmd_dev == MMD_DEV_SKEW);
    assign skew_rd = skew_sel ? skew_read(state_r, state_r.mmd_addr) : '0;

    // Post-increment: both directions, or writes only
    always_comb begin
        addr_step = 1'b0;
        case (state_r.mmd_func)
            MMD_FUNC_INC_RW: addr_step = 1'b1;
            MMD_FUNC_INC_WR: addr_step = mgmt_wr;
            default: addr_step = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = 1'b0;

        // Writes: control register, then address or data through the portal
        if (mgmt_wr) begin
            case (mgmt_addr)
                MII_REG_MMD_CTRL: begin
                    state_nxt.mmd_dev = mgmt_wdata[4:0];
                    state_nxt.mmd_func = mgmt_wdata[MMD_FUNC_LSB +: 2];
                end
                MII_REG_MMD_DATA: begin
                    if (!data_mode) begin
                        state_nxt.mmd_addr = mgmt_wdata;
                    end else if (skew_sel) begin
                        // Whole word stored so reserved bits read back
                        case (state_r.mmd_addr)
                            SKEW_REG_CTRL: state_nxt.skew_ctrl = mgmt_wdata;
                            SKEW_REG_RXD: state_nxt.skew_rxd = mgmt_wdata;
                            SKEW_REG_TXD: state_nxt.skew_txd = mgmt_wdata;
                            SKEW_REG_CLK: state_nxt.skew_clk = mgmt_wdata;
                            default: state_nxt.skew_ctrl = state_r.skew_ctrl;
                        endcase
                    end
                end
                default: state_nxt.mmd_addr = state_r.mmd_addr;
            endcase
        end

        // Reads: answer the cycle after the strobe
        if (mgmt_rd) begin
            state_nxt.rvalid = 1'b1;
            case (mgmt_addr)
                MII_REG_MMD_CTRL: begin
                    state_nxt.rdata = '0;
                    state_nxt.rdata[MMD_FUNC_LSB +: 2] = state_r.mmd_func;
                    state_nxt.rdata[4:0] = state_r.mmd_dev;
                end
                MII_REG_MMD_DATA: begin
                    state_nxt.rdata = data_mode ? skew_rd : state_r.mmd_addr;
                end
                default: state_nxt.rdata = '0;
            endcase
        end

        // Data access moves to the next register: reads and writes in MMD_FUNC_INC_RW, writes only in MMD_FUNC_INC_WR
        if ((mgmt_wr || mgmt_rd) && (mgmt_addr == MII_REG_MMD_DATA) && addr_step) begin
            state_nxt.mmd_addr = state_r.mmd_addr + 16'h0001;
        end

        // Pad offsets follow the new register image with no restart
        state_nxt.delay.tx_ctl = skew4_offset(state_nxt.skew_ctrl[CTRL_TX_LSB +: SKEW4_W]);
        state_nxt.delay.rx_ctl = skew4_offset(state_nxt.skew_ctrl[CTRL_RX_LSB +: SKEW4_W]);
        state_nxt.delay.tx_clk = skew5_offset(state_nxt.skew_clk[CLK_TX_LSB +: SKEW5_W]);
        // Receive clock carries the fixed lead on top of its own skew
        state_nxt.delay.rx_clk = 7'(signed'(skew5_offset(state_nxt.skew_clk[CLK_RX_LSB +: SKEW5_W])))
            + RX_CLK_LEAD_STEPS;
        for (int i = 0; i < 4; i++) begin
            state_nxt.delay.txd[i] = skew4_offset(state_nxt.skew_txd[SKEW4_W * i +: SKEW4_W]);
            state_nxt.delay.rxd[i] = skew4_offset(state_nxt.skew_rxd[SKEW4_W * i +: SKEW4_W]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; low enable freezes everything
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= RESET_VAL;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign mgmt_rdata = state_r.rdata;
    assign mgmt_rvalid = state_r.rvalid;
    // Offsets apply per pin; only alignment within each group matters
    assign pad_delay = state_r.delay;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive and transmit pin paths
    rgp_rx_status u_rx_status (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .rx_in(rx_in),
        .status(status),
        .rx_pin(rx_pin)
    );

    rgp_tx_sample u_tx_sample (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .tx_clk_pin(tx_clk_pin),
        .tx_ctl_pin(tx_ctl_pin),
        .txd_pin(txd_pin),
        .tx_out(tx_out),
        .tx_valid(tx_valid)
    );

endmodule // rgp_top

// >>> src/rgp_pkg.sv
// Shared constants, carrier structs and skew decoding for the RGMII pad skew block.
// Assumes a single core clock domain; pins from the MAC are synchronised by the users.
//
// Functional notes
// - Skew only matters within each pin group
// - Control skew register: rx 7:4, tx 3:0
// - Receive data skew: four nibbles, reset 0111
// - Transmit data skew: four nibbles, reset 0111
// - Clock skew: tx 9:5, rx 4:0
// - One step is about 0.06 ns
// - Five-bit code 01111 means no adjustment
// - Four-bit code 0111 means no adjustment
// - Receive clock launched 1.2 ns after data
// - Status on receive data during gap
// - Receive data bits 2:1 carry speed
// - Control pairs valid and error per edge
// - MAC sources transmit clock, device receive clock
package rgp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Management portal
    localparam logic [4:0] MII_REG_MMD_CTRL = 5'h0d;
    localparam logic [4:0] MII_REG_MMD_DATA = 5'h0e;
    localparam logic [4:0] MMD_DEV_SKEW = 5'h02;
    localparam int MMD_FUNC_LSB = 14;
    localparam logic [1:0] MMD_FUNC_ADDR = 2'h0;
    localparam logic [1:0] MMD_FUNC_DATA = 2'h1;
    localparam logic [1:0] MMD_FUNC_INC_RW = 2'h2;
    localparam logic [1:0] MMD_FUNC_INC_WR = 2'h3;

    // Skew registers inside the device-2 space
    localparam logic [15:0] SKEW_REG_CTRL = 16'h0004;
    localparam logic [15:0] SKEW_REG_RXD = 16'h0005;
    localparam logic [15:0] SKEW_REG_TXD = 16'h0006;
    localparam logic [15:0] SKEW_REG_CLK = 16'h0008;
    localparam logic [15:0] SKEW_CTRL_RST = 16'h0077;
    localparam logic [15:0] SKEW_RXD_RST = 16'h7777;
    localparam logic [15:0] SKEW_TXD_RST = 16'h7777;
    localparam logic [15:0] SKEW_CLK_RST = 16'h01ef;

    // Field layout
    localparam int SKEW4_W = 4;
    localparam int SKEW5_W = 5;
    localparam int CTRL_RX_LSB = 4;
    localparam int CTRL_TX_LSB = 0;
    localparam int CLK_TX_LSB = 5;
    localparam int CLK_RX_LSB = 0;
    localparam logic [4:0] SKEW4_NEUTRAL = 5'h07;
    localparam logic [5:0] SKEW5_NEUTRAL = 6'h0f;

    // Delay figures, in picoseconds and in steps
    localparam int SKEW_STEP_PS = 60;
    localparam int RX_CLK_LEAD_PS = 1200;
    localparam logic [6:0] RX_CLK_LEAD_STEPS = 7'(RX_CLK_LEAD_PS / SKEW_STEP_PS);

    // In-band speed codes
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic link_up;
        logic full_duplex;
        logic [1:0] speed;
    } rgp_status_s;

    typedef struct packed {
        logic dv;
        logic er;
        logic [7:0] data;
    } rgp_byte_s;

    typedef struct packed {
        logic ctl_rise;
        logic ctl_fall;
        logic [3:0] d_rise;
        logic [3:0] d_fall;
    } rgp_pin_s;

    // Two's complement pad offsets, in steps of SKEW_STEP_PS
    typedef struct packed {
        logic [5:0] tx_clk;
        logic [6:0] rx_clk;
        logic [4:0] tx_ctl;
        logic [4:0] rx_ctl;
        logic [3:0][4:0] txd;
        logic [3:0][4:0] rxd;
    } rgp_delay_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Linear decode, neutral code maps to zero offset
    function automatic logic [4:0] skew4_offset(input logic [3:0] code);
        skew4_offset = {1'b0, code} - SKEW4_NEUTRAL;
    endfunction

    function automatic logic [5:0] skew5_offset(input logic [4:0] code);
        skew5_offset = {1'b0, code} - SKEW5_NEUTRAL;
    endfunction

endpackage

// >>> src/rgp_rx_status.sv
// Receive-side pin driver: data nibbles per edge, or in-band status in the gap.
// Assumes the receive byte stream and link status are on core_clk.
`timescale 1ns/1ns
module rgp_rx_status import rgp_pkg::*; (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire rgp_byte_s rx_in,
    input wire rgp_status_s status,
    output rgp_pin_s rx_pin
);

    typedef struct packed {
        rgp_pin_s pin;
    } rgp_rxs_state_s;

    rgp_rxs_state_s state_r;
    rgp_rxs_state_s state_nxt;
    logic [3:0] status_nib;

    ////////////////////////////////////////////////////////////////////////////////
    // Status nibble: duplex, speed, link
    assign status_nib = {status.full_duplex, status.speed, status.link_up};

    // Control low on both edges means gap, so status replaces data there
    always_comb begin
        state_nxt = state_r;
        state_nxt.pin.ctl_rise = rx_in.dv;
        state_nxt.pin.ctl_fall = rx_in.dv ^ rx_in.er;
        if (!rx_in.dv && !rx_in.er) begin
            state_nxt.pin.d_rise = status_nib;
            state_nxt.pin.d_fall = status_nib;
        end else begin
            state_nxt.pin.d_rise = rx_in.data[3:0];
            state_nxt.pin.d_fall = rx_in.data[7:4];
        end
    end

    // Reset shows the gap with a down link
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign rx_pin = state_r.pin;

endmodule // rgp_rx_status

// >>> src/rgp_tx_sample.sv
// Transmit-side sampler: oversamples the MAC clock and pins, pairs both edges into a byte.
// Assumes the transmit clock is far slower than core_clk and the MAC centres it on data.
`timescale 1ns/1ns
module rgp_tx_sample import rgp_pkg::*; (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic tx_clk_pin,
    input wire logic tx_ctl_pin,
    input wire logic [3:0] txd_pin,
    output rgp_byte_s tx_out,
    output logic tx_valid
);

    typedef struct packed {
        logic [5:0] meta;
        logic [5:0] sync;
        logic clk_d;
        logic ctl_rise;
        logic [3:0] d_rise;
        rgp_byte_s out;
        logic valid;
    } rgp_txs_state_s;

    rgp_txs_state_s state_r;
    rgp_txs_state_s state_nxt;
    logic clk_s;
    logic ctl_s;
    logic [3:0] d_s;

    ////////////////////////////////////////////////////////////////////////////////
    assign {clk_s, ctl_s, d_s} = state_r.sync;

    // Two-stage synchroniser; only the second stage feeds logic
    always_comb begin
        state_nxt = state_r;
        state_nxt.meta = {tx_clk_pin, tx_ctl_pin, txd_pin};
        state_nxt.sync = state_r.meta;
        state_nxt.clk_d = clk_s;
        state_nxt.valid = 1'b0;
        // Rising edge: low nibble and enable half
        if (clk_s && !state_r.clk_d) begin
            state_nxt.ctl_rise = ctl_s;
            state_nxt.d_rise = d_s;
        end
        // Falling edge closes the byte; error is the xor of both halves
        if (!clk_s && state_r.clk_d) begin
            state_nxt.out.dv = state_r.ctl_rise;
            state_nxt.out.er = state_r.ctl_rise ^ ctl_s;
            state_nxt.out.data = {d_s, state_r.d_rise};
            state_nxt.valid = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    assign tx_out = state_r.out;
    assign tx_valid = state_r.valid;

endmodule // rgp_tx_sample

// >>> dv/rgp_top_monitor.sv
// Checker on the ports of the pad skew block top.
// Assumes one core clock domain; ce drops only while the management bus is quiet.
`timescale 1ns/1ns
module rgp_top_monitor import rgp_pkg::*; (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid,
    input wire rgp_status_s status,
    input wire rgp_byte_s rx_in,
    input wire rgp_pin_s rx_pin,
    input wire rgp_delay_s pad_delay,
    input wire logic tx_clk_pin,
    input wire rgp_byte_s tx_out,
    input wire logic tx_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////
    // Management answers come exactly one cycle after the strobe
    rd_answer_a: assert property (ce && mgmt_rd |=> mgmt_rvalid)
        else $error("read strobe not answered");
    rd_stray_a: assert property (!(ce && mgmt_rd) |=> !mgmt_rvalid)
        else $error("read answer without strobe");
    rdata_hold_a: assert property (!mgmt_rvalid |-> $stable(mgmt_rdata))
        else $error("read data moved without answer");
    // Offsets move only as the result of a register write on the previous edge
    delay_hold_a: assert property (!mgmt_wr |=> $stable(pad_delay))
        else $error("pad offsets moved without write");
    ////////////////////////////////////////////////////////////
    // Receive pins: status in the gap, data nibbles otherwise
    status_ins_a: assert property (ce && !rx_in.dv && !rx_in.er |=>
        rx_pin.d_rise == {$past(status.full_duplex), $past(status.speed),
        $past(status.link_up)} && rx_pin.d_fall == rx_pin.d_rise)
        else $error("gap status nibble wrong");
    rx_data_a: assert property (ce && rx_in.dv |=>
        {rx_pin.d_fall, rx_pin.d_rise} == $past(rx_in.data))
        else $error("receive nibbles wrong");
    rx_ctl_a: assert property (ce |=> rx_pin.ctl_rise == $past(rx_in.dv) &&
        rx_pin.ctl_fall == ($past(rx_in.dv) ^ $past(rx_in.er)))
        else $error("receive control wrong");
    ////////////////////////////////////////////////////////////
    // Transmit bytes: a bounded wait after the falling clock, one-cycle pulse
    tx_byte_a: assert property ($fell(tx_clk_pin) |-> ##[1:5] tx_valid)
        else $error("no byte after transmit clock fall");
    tx_pulse_a: assert property (tx_valid |=> !tx_valid)
        else $error("byte strobe longer than one cycle");
    tx_hold_a: assert property (!tx_valid |-> $stable(tx_out))
        else $error("byte changed without strobe");
endmodule // rgp_top_monitor

// >>> dv/rgp_mac_model.sv
// MAC model driving the transmit clock, control and data pins.
// Assumes core_clk is far faster; the clock stands still between bytes.
`timescale 1ns/1ns
module rgp_mac_model (
    input wire logic core_clk,
    output logic tx_clk_pin,
    output logic tx_ctl_pin,
    output logic [3:0] txd_pin
);
    ////////////////////////////////////////////////////////////
    // Idle pins at start
    initial begin
        tx_clk_pin = 1'b0;
        tx_ctl_pin = 1'b0;
        txd_pin = 4'h0;
    end
    // Two core cycles each side of every edge centres the clock in the eye,
    // giving a 320 ns clock period within the byte
    task automatic send(input logic dv, input logic er, input logic [7:0] d);
        @(posedge core_clk);
        tx_ctl_pin <= dv;
        txd_pin <= d[3:0];
        repeat (2) @(posedge core_clk);
        tx_clk_pin <= 1'b1;
        repeat (2) @(posedge core_clk);
        tx_ctl_pin <= dv ^ er;
        txd_pin <= d[7:4];
        repeat (2) @(posedge core_clk);
        tx_clk_pin <= 1'b0;
        repeat (2) @(posedge core_clk);
        tx_ctl_pin <= ~(dv ^ er); // Hold over: stale levels are not kept
        txd_pin <= ~d[7:4];
    endtask
endmodule // rgp_mac_model

// >>> dv/rgp_top_tb.sv
// Bench for the pad skew block: skew registers, in-band status and byte paths.
// Assumes the MAC model owns the transmit pins; ce drops once, during the receive test.
`timescale 1ns/1ns
module rgp_top_tb import rgp_pkg::*;;
    logic core_clk, nrst, ce, mgmt_wr, mgmt_rd, mgmt_rvalid, tx_valid;
    logic tx_clk_pin, tx_ctl_pin;
    logic [3:0] txd_pin;
    logic [4:0] mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata;
    rgp_status_s status;
    rgp_byte_s rx_in, tx_out;
    rgp_pin_s rx_pin;
    rgp_delay_s pad_delay;
    int failures, num_checks, cyc;

    rgp_top i_rgp_top (.core_clk(core_clk), .nrst(nrst), .ce(ce), .mgmt_wr(mgmt_wr),
        .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .status(status), .rx_in(rx_in),
        .rx_pin(rx_pin), .pad_delay(pad_delay), .tx_clk_pin(tx_clk_pin),
        .tx_ctl_pin(tx_ctl_pin), .txd_pin(txd_pin), .tx_out(tx_out), .tx_valid(tx_valid));
    rgp_mac_model i_rgp_mac_model (.core_clk(core_clk), .tx_clk_pin(tx_clk_pin),
        .tx_ctl_pin(tx_ctl_pin), .txd_pin(txd_pin));

    ////////////////////////////////////////////////////////////
    // 25 MHz core clock and a cycle ceiling against hangs
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    // Offset of a four-bit code: linear, neutral at 0111
    function automatic logic [4:0] off4(input logic [3:0] c);
        return {1'b0, c} - 5'h07;
    endfunction

    ////////////////////////////////////////////////////////////
    // Management strobes are one-cycle pulses launched on the edge
    task automatic mwr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        mgmt_wr <= 1'b1;
        mgmt_addr <= a;
        mgmt_wdata <= d;
        @(posedge core_clk);
        mgmt_wr <= 1'b0;
    endtask
    task automatic mrd(input logic [4:0] a, output logic [15:0] d);
        @(posedge core_clk);
        mgmt_rd <= 1'b1;
        mgmt_addr <= a;
        @(posedge core_clk);
        mgmt_rd <= 1'b0;
        // Answer stands for the one cycle after the taking edge
        #1;
        chk("rvalid", 64'h1, 64'(mgmt_rvalid));
        d = mgmt_rdata;
    endtask
    task automatic sel(input logic [15:0] r);
        mwr(5'h0d, 16'h0002);
        mwr(5'h0e, r);
        mwr(5'h0d, 16'h4002);
    endtask
    task automatic rd_skew(input logic [15:0] r, input logic [15:0] exp);
        logic [15:0] d;
        sel(r);
        mrd(5'h0e, d);
        chk("skew reg", 64'(exp), 64'(d));
    endtask

    ////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        rgp_delay_s e;
        e = '0;
        e.rx_clk = 7'h14; // Fixed receive clock lead of 20 steps
        chk("pad_delay", 64'(e), 64'(pad_delay));
        rd_skew(16'h0004, 16'h0077);
        rd_skew(16'h0005, 16'h7777);
        rd_skew(16'h0006, 16'h7777);
        rd_skew(16'h0008, 16'h01ef);
    endtask
    task automatic t_write();
        logic [15:0] rg[4] = '{16'h0004, 16'h0005, 16'h0006, 16'h0008};
        logic [15:0] va[4] = '{16'hab90, 16'hf08c, 16'h1e3f, 16'hfc1f};
        rgp_delay_s e;
        for (int i = 0; i < 4; i++) begin
            sel(rg[i]);
            mwr(5'h0e, va[i]);
        end
        repeat (2) @(posedge core_clk);
        #1;
        e.tx_clk = 6'h31; // Code 0 is 15 steps short
        e.rx_clk = 7'h24; // Code 31 is 16 steps long, plus the lead
        e.tx_ctl = off4(4'h0);
        e.rx_ctl = off4(4'h9);
        e.rxd = {off4(4'hf), off4(4'h0), off4(4'h8), off4(4'hc)};
        e.txd = {off4(4'h1), off4(4'he), off4(4'h3), off4(4'hf)};
        chk("pad_delay", 64'(e), 64'(pad_delay));
        for (int i = 0; i < 4; i++) rd_skew(rg[i], va[i]);
    endtask
    task automatic t_refuse();
        logic [15:0] d;
        mwr(5'h0d, 16'h0003);
        mwr(5'h0e, 16'h0004);
        mwr(5'h0d, 16'h4003);
        mwr(5'h0e, 16'h1234);
        mrd(5'h0e, d);
        chk("other device", 64'h0, 64'(d));
        mrd(5'h05, d);
        chk("unmapped", 64'h0, 64'(d));
        rd_skew(16'h0004, 16'hab90);
    endtask
    task automatic rx_step(input rgp_byte_s b, input rgp_status_s s, input rgp_pin_s exp);
        @(posedge core_clk);
        rx_in <= b;
        status <= s;
        @(posedge core_clk);
        #1;
        chk("rx_pin", 64'(exp), 64'(rx_pin));
    endtask
    task automatic t_rx();
        rgp_status_s s;
        for (int i = 0; i < 4; i++) begin
            s = {i[0], ~i[0], i[1:0]};
            rx_step('0, s, {2'b00, {2{s.full_duplex, s.speed, s.link_up}}});
        end
        rx_step({1'b1, 1'b0, 8'ha5}, s, {2'b11, 4'h5, 4'ha});
        rx_step({1'b1, 1'b1, 8'h3c}, s, {2'b10, 4'hc, 4'h3});
        rx_step({1'b0, 1'b1, 8'h0f}, s, {2'b01, 4'hf, 4'h0});
        // Low enable freezes the pins: a gap must not show status yet
        ce <= 1'b0;
        rx_step('0, s, {2'b01, 4'hf, 4'h0});
        ce <= 1'b1;
    endtask
    task automatic tx_byte(input logic dv, input logic er, input logic [7:0] d);
        logic seen;
        seen = 1'b0;
        fork
            i_rgp_mac_model.send(dv, er, d);
            for (int k = 0; k < 30 && !seen; k++) begin
                @(posedge core_clk);
                #1;
                seen = tx_valid;
            end
        join
        chk("tx_valid", 64'h1, 64'(seen));
        chk("tx_out", 64'({dv, er, d}), 64'(tx_out));
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence: reset five cycles, then each scenario in turn
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_addr = '0;
        mgmt_wdata = '0;
        status = '0;
        rx_in = '0;
        failures = 0;
        num_checks = 0;
        cyc = 0;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset_vals();
        t_write();
        t_refuse();
        t_rx();
        tx_byte(1'b1, 1'b0, 8'ha5);
        tx_byte(1'b1, 1'b1, 8'h3c);
        close_out();
    end
endmodule // rgp_top_tb

bind rgp_top rgp_top_monitor i_rgp_top_monitor (.core_clk(core_clk), .nrst(nrst), .ce(ce),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .status(status), .rx_in(rx_in), .rx_pin(rx_pin), .pad_delay(pad_delay),
    .tx_clk_pin(tx_clk_pin), .tx_out(tx_out), .tx_valid(tx_valid));
